// >>> core/retexec_cfg.svh
// constants for the return and no-operation execution block
// assumes a 14-bit instruction word and a 13-bit program counter
`ifndef RETEXEC_CFG_SVH
`define RETEXEC_CFG_SVH
`define OPC_NOP_MASK 14'h3F9F
`define OPC_NOP_VAL 14'h0000
`define OPC_RETFI 14'h0009
`define OPC_RET 14'h0008
`define OPC_RETLIT_MASK 14'h3C00
`define OPC_RETLIT_VAL 14'h3400
`define LIT_LSB 0
`define LIT_MSB 7
`define PC_RESET 13'h0000
`define W_RESET 8'h00
`define PC_STEP 13'h0001
`define INT_EN_RESET 1'h0
`define INT_EN_SET 1'h1
`define STATUS_RESET 8'h00
`endif

// >>> core/retexec_pkg.sv
// types for the return and no-operation execution block
// assumes the includer supplies nothing else
package retexec_pkg;
   // one-hot sequencer states
   typedef enum logic [1:0] {
      st_exec = 2'b01, // first cycle of an instruction
      st_flush = 2'b10 // second cycle of a return
   } seq_t;
   typedef logic [12:0] pc_t; // program counter width
endpackage : retexec_pkg

// >>> core/opc_if.sv
// carrier between execution top and decoder
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface opc_if;
   logic [13:0] insn; // instruction word
   logic is_nop; // no-operation decoded
   logic is_retfi; // return from interrupt
   logic is_ret; // plain return
   logic is_retlit; // return with literal
   modport dec (input insn, output is_nop, is_retfi, is_ret, is_retlit);
   modport exe (output insn, input is_nop, is_retfi, is_ret, is_retlit);
endinterface : opc_if

// >>> core/opc_decode.sv
// opcode decoder for the four instructions
// assumes a stable instruction word in the same cycle
`timescale 1ns/1ps
`include "retexec_cfg.svh"
module opc_decode (
   opc_if.dec bus
);
   // ***********************
   // decode
   // ***********************
   assign bus.is_nop = (bus.insn & `OPC_NOP_MASK) == `OPC_NOP_VAL;
   assign bus.is_retfi = bus.insn == `OPC_RETFI;
   assign bus.is_ret = bus.insn == `OPC_RET;
   assign bus.is_retlit = (bus.insn & `OPC_RETLIT_MASK) == `OPC_RETLIT_VAL;
endmodule : opc_decode

// >>> core/return_and_nop_execution.sv
// execution of no-operation and of the three return instructions
// assumes the core pops its return stack whenever pop is high
// assumes the core holds off its own fetch while busy is high
// assumes the status flags belong to the core, this block only mirrors them
`timescale 1ns/1ps
`include "retexec_cfg.svh"
module return_and_nop_execution (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [13:0] insn, // instruction in execute
   input wire logic insn_valid, // instruction present
   input wire retexec_pkg::pc_t top_of_stack, // current stack top
   input wire logic [7:0] status_in, // flags from core
   output logic pop, // stack pop strobe
   output retexec_pkg::pc_t pc_q, // program counter
   output logic [7:0] w_q, // working register
   output logic global_interrupt_enable_q, // interrupt enable bit
   output logic [7:0] status_q, // status flags held
   output logic busy // second cycle in progress
);
   import retexec_pkg::*;
   // carrier to the opcode decoder
   opc_if ob();
   // sequencer state and its next value
   seq_t st_q;
   seq_t st_d;
   // ***********************
   // decoder
   // ***********************
   // the decoder is pure logic, so the decode is ready in the cycle the word arrives
   opc_decode u_dec (
      .bus(ob.dec)
   );
   // word under execution goes straight to the decoder
   assign ob.insn = insn;
   // a word is taken only in the first slot
   // a word offered in the dead slot is dropped, and no port shows it
   wire logic exec = insn_valid && (st_q == st_exec); // taking new insn
   // any of the three returns
   wire logic any_ret = ob.is_ret || ob.is_retfi || ob.is_retlit;
   // same pop for the other returns
   // pop is combinational so the core sees it in the cycle the return is taken
   assign pop = exec && any_ret;
   // busy marks the dead second slot of a return
   assign busy = st_q == st_flush;
   // ***********************
   // sequencer
   // ***********************
   // second cycle for returns
   // the popped address reaches pc at the end of the first slot; the second
   // slot stands for the prefetched word that the jump throws away
   always_comb begin
      // hold by default
      st_d = st_q;
      unique case (st_q)
         st_exec: begin
            // a taken return opens the dead slot
            if (pop) begin
               st_d = st_flush;
            end
         end
         st_flush: begin
            st_d = st_exec; // discarded fetch slot
         end
         default: begin
            st_d = st_exec; // illegal code recovers
         end
      endcase
   end
   // state register, sync reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         // reset lands in the first slot, ready for a word
         st_q <= st_exec;
      end else begin
         st_q <= st_d;
      end
   end
   // ***********************
   // datapath
   // ***********************
   // pc from stack on return, else step
   // same load for the other returns
   // the step wraps at the top of program memory, as a plain counter does
   wire pc_t pc_d = pop ? top_of_stack : (pc_q + `PC_STEP);
   // program counter, moves only when a word is taken
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pc_q <= `PC_RESET;
      end else if (exec) begin
         pc_q <= pc_d;
      end
   end
   // literal into working register
   // literal field of the word under execution
   wire logic [7:0] lit = insn[`LIT_MSB:`LIT_LSB];
   // working register, written here only by the literal return
   always_ff @(posedge core_clk) begin
      if (srst) begin
         w_q <= `W_RESET;
      end else if (exec && ob.is_retlit) begin
         w_q <= lit;
      end
   end
   // interrupt enable set on return from interrupt only
   // limitation: there is no clear input, so the bit falls only at reset;
   // clearing on interrupt entry is left to the core around this block
   always_ff @(posedge core_clk) begin
      if (srst) begin
         global_interrupt_enable_q <= `INT_EN_RESET;
      end else if (exec && ob.is_retfi) begin
         global_interrupt_enable_q <= `INT_EN_SET;
      end
   end
   // flags tracked, never changed here
   // a plain copy keeps every flag as the core left it, returns included;
   // the price is one cycle of lag behind the core's own flags
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_q <= `STATUS_RESET;
      end else begin
         status_q <= status_in;
      end
   end
   // ***********************
   // checks
   // ***********************
   // all checks below sit out the sync reset; reset_val_a alone watches it
   // each entry sequence but ret_take_s is the taking edge of one kind of word
   // the enable and w_q hold checks compare against the previous edge, so they cover
   // every cycle, not only the cycles in which a word is taken
   // entry into any return, first slot
   sequence ret_take_s;
      exec && any_ret;
   endsequence
   // entry into a literal return
   sequence lit_take_s;
      exec && ob.is_retlit;
   endsequence
   // entry into an interrupt return
   sequence retfi_take_s;
      exec && ob.is_retfi;
   endsequence
   // entry into a plain return
   sequence plain_take_s;
      exec && ob.is_ret;
   endsequence
   // entry into a no-operation
   sequence idle_take_s;
      exec && ob.is_nop;
   endsequence
   // the dead slot, then a free first slot
   sequence dead_slot_s;
      busy ##1 !busy;
   endsequence
   // reset puts every register back to its start value
   reset_val_a: assert property (@(posedge core_clk)
      srst |=> pc_q == `PC_RESET && w_q == `W_RESET && !busy
      && global_interrupt_enable_q == `INT_EN_RESET && status_q == `STATUS_RESET)
      else $error("reset value wrong");
   ret_pc_a: assert property (@(posedge core_clk) disable iff (srst)
      ret_take_s |=> pc_q == $past(top_of_stack)) else $error("pc not from stack");
   plain_pop_a: assert property (@(posedge core_clk) disable iff (srst)
      plain_take_s |-> pop) else $error("return no pop");
   plain_keep_a: assert property (@(posedge core_clk) disable iff (srst)
      plain_take_s |=> $stable(w_q) && $stable(global_interrupt_enable_q))
      else $error("return touched registers");
   ret_two_a: assert property (@(posedge core_clk) disable iff (srst)
      ret_take_s |=> dead_slot_s) else $error("return not two cycles");
   lit_w_a: assert property (@(posedge core_clk) disable iff (srst)
      lit_take_s |=> w_q == $past(insn[`LIT_MSB:`LIT_LSB])) else $error("literal lost");
   lit_pop_a: assert property (@(posedge core_clk) disable iff (srst)
      lit_take_s |-> pop) else $error("literal no pop");
   lit_pc_a: assert property (@(posedge core_clk) disable iff (srst)
      lit_take_s |=> pc_q == $past(top_of_stack)) else $error("literal pc wrong");
   lit_two_a: assert property (@(posedge core_clk) disable iff (srst)
      lit_take_s |=> busy && !pop) else $error("literal one cycle");
   dead_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      busy |=> pc_q == $past(pc_q) && w_q == $past(w_q)
      && global_interrupt_enable_q == $past(global_interrupt_enable_q))
      else $error("dead slot changed state");
   int_en_set_a: assert property (@(posedge core_clk) disable iff (srst)
      retfi_take_s |=> global_interrupt_enable_q && pc_q == $past(top_of_stack))
      else $error("interrupt return wrong");
   int_en_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      !(exec && ob.is_retfi)
      |=> global_interrupt_enable_q == $past(global_interrupt_enable_q))
      else $error("enable changed");
   retfi_pop_a: assert property (@(posedge core_clk) disable iff (srst)
      retfi_take_s |-> pop) else $error("interrupt return no pop");
   flags_keep_a: assert property (@(posedge core_clk) disable iff (srst)
      plain_take_s |=> status_q == $past(status_in)) else $error("flags changed");
   nop_step_a: assert property (@(posedge core_clk) disable iff (srst)
      idle_take_s |=> pc_q == $past(pc_q) + `PC_STEP && !busy
      && $stable(w_q) && $stable(global_interrupt_enable_q))
      else $error("nop misbehaved");
   idle_pop_a: assert property (@(posedge core_clk) disable iff (srst)
      idle_take_s |-> !pop) else $error("nop popped stack");
   w_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      !(exec && ob.is_retlit) |=> w_q == $past(w_q))
      else $error("working register changed");
endmodule : return_and_nop_execution

// >>> tb/tb_return_and_nop_execution.sv
// random bench for the return and no-operation block
// assumes the core files compile first, header on include path
`timescale 1ns/1ps
`include "retexec_cfg.svh"
module tb_return_and_nop_execution;
   import retexec_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic insn_valid = 1'b0;
   logic [13:0] insn = 14'h0000;
   logic [13:0] nx; // next word drawn
   pc_t top_of_stack = 13'h0000;
   logic [7:0] status_in = 8'h00;
   logic pop, global_interrupt_enable_q, busy;
   pc_t pc_q;
   logic [7:0] w_q, status_q;
   // model state, reset values
   pc_t e_pc = 13'h0000;
   logic [7:0] e_w = 8'h00, e_st = 8'h00;
   logic e_int_en = 1'b0, e_busy = 1'b0, e_pop;
   logic [31:0] seed = 32'h0000000A;
   // literal 255, refused word, literal 0, refused word, nop with its free bits set
   logic [13:0] corner [5] = '{14'h34FF, 14'h0009, 14'h3700, 14'h0008, 14'h0060};
   int n_fail = 0, n_tests = 0;
   return_and_nop_execution u_dut (.core_clk(core_clk), .srst(srst), .insn(insn),
      .insn_valid(insn_valid), .top_of_stack(top_of_stack), .status_in(status_in),
      .pop(pop), .pc_q(pc_q), .w_q(w_q), .global_interrupt_enable_q(global_interrupt_enable_q),
      .status_q(status_q), .busy(busy));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // 3 literal return, 2 interrupt return, 1 plain return, 0 the rest
   function automatic logic [1:0] kind(input logic [13:0] i);
      if ((i & `OPC_RETLIT_MASK) == `OPC_RETLIT_VAL) return 2'h3;
      if (i == `OPC_RETFI) return 2'h2;
      if (i == `OPC_RET) return 2'h1;
      return 2'h0;
   endfunction : kind
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // watchdog, about two and a half times the planned run
   initial begin
      #50000;
      n_fail++;
      test_done();
   end
   // ***********************
   // main sequence
   // ***********************
   initial begin
      repeat (10) @(negedge core_clk);
      srst = 1'b0;
      for (int n = 0; n < 400; n++) begin
         @(negedge core_clk);
         chk(16'(pc_q), 16'(e_pc));
         chk(16'(w_q), 16'(e_w));
         chk(16'(global_interrupt_enable_q), 16'(e_int_en));
         chk(16'(busy), 16'(e_busy));
         chk(16'(status_q), 16'(e_st));
         // mid-run reset for two edges, then the start values
         if (n == 200) begin
            srst = 1'b1;
            insn_valid = 1'b0;
            repeat (2) @(negedge core_clk);
            chk(16'(pc_q), 16'(`PC_RESET));
            chk(16'(w_q), 16'(`W_RESET));
            chk(16'(global_interrupt_enable_q), 16'(`INT_EN_RESET));
            chk(16'(busy), 16'h0000);
            chk(16'(status_q), 16'(`STATUS_RESET));
            srst = 1'b0;
            e_pc = `PC_RESET;
            e_w = `W_RESET;
            e_int_en = `INT_EN_RESET;
            e_busy = 1'b0;
         end
         seed = xs(seed);
         case (seed[10:8])
            3'h0: nx = `OPC_RET;
            3'h1: nx = `OPC_RETFI;
            3'h2, 3'h3: nx = `OPC_RETLIT_VAL | (seed[13:0] & 14'h03FF);
            3'h4: nx = 14'h0800 | (seed[13:0] & 14'h00FF);
            default: nx = seed[13:0] & 14'h0060;
         endcase
         insn = (n < 5) ? corner[n] : nx;
         insn_valid = (n < 5) || (seed[20:18] != 3'h0);
         top_of_stack = seed[31:19];
         status_in = seed[29:22];
         e_st = status_in;
         #1;
         e_pop = insn_valid && !e_busy && (kind(insn) != 2'h0);
         chk(16'(pop), 16'(e_pop));
         // model of a taken word
         if (insn_valid && !e_busy) begin
            e_pc = e_pop ? top_of_stack : e_pc + `PC_STEP;
            if (kind(insn) == 2'h3) e_w = insn[7:0];
            if (kind(insn) == 2'h2) e_int_en = 1'b1;
         end
         e_busy = e_pop;
      end
      test_done();
   end
endmodule : tb_return_and_nop_execution
